//--- dbl_dac_model.sv
// Purpose: behavioural word-wide and byte-wide double-buffered dacs on the pins
// Assumes: strobes active low; every register is a transparent latch
// Notes: no clock; outputs show each device's dac register
`timescale 1ns/1ps
`default_nettype none
module dbl_dac_model
   import dbl_pkg::*;
(
   input wire logic [CODE_W-1:0] dataLines,
   input wire logic highSelN,
   input wire logic lowSelN,
   input wire logic wrN,
   input wire logic loadN,
   input wire logic byteSelN,
   input wire logic [1:0] byteAddr,
   output logic [CODE_W-1:0] wordCode,
   output logic [CODE_W-1:0] byteCode
);
   logic [5:0] wHigh = 6'h00; // word device input latches
   logic [7:0] wLow = 8'h00;
   logic [13:0] wDac = 14'h0000; // word device dac register
   logic [5:0] bHigh = 6'h00; // byte device input latches, low lines only
   logic [7:0] bLow = 8'h00;
   logic [13:0] bDac = 14'h0000;
   logic allLow; // all four word strobes low
   // latches follow while enabled and hold otherwise; no reset, like the part
   always @* begin
      allLow = !highSelN && !lowSelN && !wrN && !loadN;
      if (!highSelN && !wrN && (loadN || allLow)) wHigh = dataLines[13:8];
      if (!lowSelN && !wrN && (loadN || allLow)) wLow = dataLines[7:0];
      if (!loadN && ((highSelN && lowSelN) || allLow)) wDac = {wHigh, wLow};
      if (!byteSelN && !wrN && byteAddr == LOC_HIGH) bHigh = dataLines[5:0];
      if (!byteSelN && !wrN && byteAddr == LOC_LOW) bLow = dataLines[7:0];
      if (!byteSelN && !wrN && byteAddr == LOC_LOAD) bDac = {bHigh, bLow};
   end
   assign wordCode = wDac;
   assign byteCode = bDac;
endmodule
`default_nettype wire

//--- dbl_host_ctrl.sv
// Purpose: host side controller that writes codes into a double-buffered 14-bit dac
// Assumes: software reaches it over apb; the dac is write-only, so no pin is read back
// Notes: word-wide and byte-wide pin sets are both driven; a control bit picks one
`timescale 1ns/1ps
`default_nettype none
// How it works
// - load all input registers, then one shared load
// - byte variant uses two transfers on low lines
// - after both bytes, one write to load location
// - decode maps four locations; high, low, load used
// - upper six bits right-justified, then lower eight
module dbl_host_ctrl
   import dbl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   // apb slave side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins to the device
   output logic [CODE_W-1:0] dac_data_lines,
   output logic high_byte_select_n,
   output logic low_byte_select_n,
   output logic write_strobe_n,
   output logic load_dac_strobe_n,
   // byte-wide variant only
   output logic byte_dev_select_n,
   output logic [1:0] byte_addr_lines
);

   // registered state; each but timerStrobe and timerDone has a next_ value from one always_comb
   // and is copied on every edge by the always_ff at the bottom
   dbl_state_type state, next_state; // current pin step
   logic [2:0] ctrl, next_ctrl; // byte mode, transparent, defer load
   logic [CODE_W-1:0] code, next_code; // last code written by software while not busy
   logic overrun, next_overrun; // request refused while busy
   logic startTimer, next_startTimer; // kicks the pulse timer
   logic timerStrobe; // strobe window of the current access
   logic timerDone; // access finished

   // next values of the registered outputs; no pin comes from gates
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic [CODE_W-1:0] next_dac_data_lines;
   logic next_high_byte_select_n;
   logic next_low_byte_select_n;
   logic next_write_strobe_n;
   logic next_load_dac_strobe_n;
   logic next_byte_dev_select_n;
   logic [1:0] next_byte_addr_lines;

   // decoded bus conditions, all same-cycle gates
   logic access; // access phase before the answer
   logic wrFire; // write takes effect this edge
   logic mapped; // address hits one of our words
   logic busy; // a pin sequence is running

   // control fields, decoded once
   logic byteMode;
   logic transparent;
   logic deferLoad;
   logic dataReq; // software wrote a new code
   logic loadReq; // software asked for a load alone

   // one timer is enough: only one pin access runs at a time, and
   // every step of both variants gets the same setup, width and hold
   dbl_pulse_timer timer (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .start(startTimer),
      .strobe(timerStrobe),
      .done(timerDone)
   );

   // control fields and bus decode
   // a write takes effect only at the edge where pready is seen high,
   // while the master still holds its address and data
   assign byteMode = ctrl[CTRL_BYTE_MODE];
   assign transparent = ctrl[CTRL_TRANSPARENT];
   assign deferLoad = ctrl[CTRL_DEFER_LOAD];
   assign busy = (state != ST_IDLE);
   assign access = psel && penable && !pready;
   assign wrFire = psel && penable && pready && pwrite;
   assign mapped = (paddr == REG_CTRL) || (paddr == REG_DATA) ||
                   (paddr == REG_CMD) || (paddr == REG_STATUS);
   // requests to the pin sequencer
   assign dataReq = wrFire && (paddr == REG_DATA);
   assign loadReq = wrFire && (paddr == REG_CMD) && pwdata[CMD_LOAD];

   // apb slave: one wait state, read data and error taken from registers
   // unmapped offsets answer with pslverr and read as zero
   // prdata holds between reads so a slow master can still pick it up
   always_comb begin
      next_pready = access;
      next_pslverr = access && !mapped;
      // outside a read access the read data keeps its last value
      next_prdata = prdata;
      // read data is latched in the wait cycle, stands in the answer cycle
      if (access && !pwrite) begin
         next_prdata = 32'h0000_0000;
         unique case (paddr)
            REG_CTRL: next_prdata[2:0] = ctrl;
            REG_DATA: next_prdata[CODE_W-1:0] = code;
            // status: busy and the sticky overrun flag
            REG_STATUS: begin
               next_prdata[STAT_BUSY] = busy;
               next_prdata[STAT_OVERRUN] = overrun;
            end
            // the command word is write-only and reads as zero
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // software state; the overrun set wins over a clear in the same edge
   always_comb begin
      // hold everything unless software writes it
      next_ctrl = ctrl;
      next_code = code;
      next_overrun = overrun;
      // mode changes mid-sequence would split a code across variants
      if (wrFire && (paddr == REG_CTRL) && !busy) begin
         next_ctrl = pwdata[2:0];
      end
      // overrun is write-one-to-clear
      if (wrFire && (paddr == REG_STATUS) && pwdata[STAT_OVERRUN]) begin
         next_overrun = 1'b0;
      end
      // a code or load while a sequence runs is refused and flagged;
      // taking it would tear the pins, so software polls busy first
      if ((dataReq || loadReq) && busy) begin
         next_overrun = 1'b1;
      end else if (dataReq) begin
         next_code = pwdata[CODE_W-1:0];
      end
   end

   // step sequencer: a new step starts the timer, the timer's done ends it
   // byte variant: high, low, then load; word variant: both bytes, then load
   // the timer start is registered, so it begins one edge into the step
   always_comb begin
      // stay in the step until the timer reports done
      next_state = state;
      next_startTimer = 1'b0;
      unique case (state)
         ST_IDLE: begin
            // transparent word mode needs no sequence at all
            if (dataReq && byteMode) begin
               next_state = ST_HIGH;
               next_startTimer = 1'b1;
            end else if (dataReq && !transparent) begin
               // word variant, input registers first
               next_state = ST_WORD;
               next_startTimer = 1'b1;
            end else if (loadReq && !transparent) begin
               // load alone, for a strobe shared by several converters
               next_state = ST_LOAD;
               next_startTimer = 1'b1;
            end
         end
         ST_WORD: begin
            if (timerDone) begin
               // deferring leaves the load for one shared strobe later
               next_state = deferLoad ? ST_IDLE : ST_LOAD;
               next_startTimer = !deferLoad;
            end
         end
         ST_HIGH: begin
            // high byte is in its input register now
            if (timerDone) begin
               next_state = ST_LOW;
               next_startTimer = 1'b1;
            end
         end
         ST_LOW: begin
            // both bytes are in the input registers now
            if (timerDone) begin
               next_state = deferLoad ? ST_IDLE : ST_LOAD;
               next_startTimer = !deferLoad;
            end
         end
         ST_LOAD: begin
            // the sequence is over, so no new start and busy drops
            if (timerDone) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   // pin values per step; the device latches follow while strobes are low
   // a step's pins settle as its timer starts, so they lead the strobe
   // by the setup time and stay until the hold time has passed
   always_comb begin
      next_dac_data_lines = dac_data_lines;
      // every strobe and select idles high outside its step, except in transparent word mode where idle holds the word-wide ones low
      next_high_byte_select_n = 1'b1;
      next_low_byte_select_n = 1'b1;
      next_write_strobe_n = 1'b1;
      next_load_dac_strobe_n = 1'b1;
      next_byte_dev_select_n = 1'b1;
      next_byte_addr_lines = LOC_IDLE;
      unique case (state)
         ST_IDLE: begin
            // transparency is ignored by the pins in byte mode: that variant lacks it
            if (transparent && !byteMode) begin
               // every stage open, so the new code reaches the output at once
               next_high_byte_select_n = 1'b0;
               next_low_byte_select_n = 1'b0;
               next_write_strobe_n = 1'b0;
               next_load_dac_strobe_n = 1'b0;
               next_dac_data_lines = next_code;
            end
         end
         ST_WORD: begin
            // both selects low fill both input registers in one access
            next_dac_data_lines = code;
            next_high_byte_select_n = 1'b0;
            next_low_byte_select_n = 1'b0;
            next_write_strobe_n = !timerStrobe;
         end
         ST_HIGH: begin
            // upper six bits on the low lines, unused lines held low
            next_dac_data_lines = {8'h00, code[CODE_W-1:CODE_W-HIGH_W]};
            next_byte_dev_select_n = 1'b0;
            next_byte_addr_lines = LOC_HIGH;
            next_write_strobe_n = !timerStrobe;
         end
         ST_LOW: begin
            // lower eight bits on the low lines
            next_dac_data_lines = {6'h00, code[CODE_W-HIGH_W-1:0]};
            next_byte_dev_select_n = 1'b0;
            next_byte_addr_lines = LOC_LOW;
            next_write_strobe_n = !timerStrobe;
         end
         ST_LOAD: begin
            // byte variant writes the load location; word pulses the load line
            if (byteMode) begin
               // the data carried with the load write is ignored by the device
               next_byte_dev_select_n = 1'b0;
               next_byte_addr_lines = LOC_LOAD;
               next_write_strobe_n = !timerStrobe;
            end else begin
               // selects stay high so only the dac register moves
               next_load_dac_strobe_n = !timerStrobe;
            end
         end
      endcase
   end

   // all state and every pin registered; strobes and selects idle high out of reset
   // asynchronous reset puts every pin at its inactive level, so the
   // device sees no write while the controller is held in reset
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         // strobes and selects high, data lines and address low
         state <= ST_IDLE;
         ctrl <= CTRL_RESET;
         code <= CODE_RESET;
         overrun <= 1'b0;
         startTimer <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         dac_data_lines <= CODE_RESET;
         high_byte_select_n <= 1'b1;
         low_byte_select_n <= 1'b1;
         write_strobe_n <= 1'b1;
         load_dac_strobe_n <= 1'b1;
         byte_dev_select_n <= 1'b1;
         byte_addr_lines <= LOC_IDLE;
      end else begin
         // plain copy of the next values, nothing computed here
         state <= next_state;
         ctrl <= next_ctrl;
         code <= next_code;
         overrun <= next_overrun;
         startTimer <= next_startTimer;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         dac_data_lines <= next_dac_data_lines;
         high_byte_select_n <= next_high_byte_select_n;
         low_byte_select_n <= next_low_byte_select_n;
         write_strobe_n <= next_write_strobe_n;
         load_dac_strobe_n <= next_load_dac_strobe_n;
         byte_dev_select_n <= next_byte_dev_select_n;
         byte_addr_lines <= next_byte_addr_lines;
      end
   end

endmodule
`default_nettype wire

//--- dbl_host_ctrl_assertions.sv
// Purpose: concurrent checks on the pin side and apb side of the dac host controller
// Assumes: one clock domain; reset nrst low active
// Notes: bound to dbl_host_ctrl from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module dbl_host_ctrl_assertions
   import dbl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [CODE_W-1:0] dac_data_lines,
   input wire logic high_byte_select_n,
   input wire logic low_byte_select_n,
   input wire logic write_strobe_n,
   input wire logic load_dac_strobe_n,
   input wire logic byte_dev_select_n,
   input wire logic [1:0] byte_addr_lines
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // end of a high byte write pulse on the byte-wide pins
   sequence s_high_end;
      !write_strobe_n && !byte_dev_select_n && byte_addr_lines == LOC_HIGH ##1 write_strobe_n;
   endsequence
   // a low byte write pulse on the byte-wide pins
   sequence s_low_write;
      !write_strobe_n && !byte_dev_select_n && byte_addr_lines == LOC_LOW;
   endsequence
   // load strobe excluded so the transparent idle state is not taken for a pulse
   a_strobe_width: assert property ($fell(write_strobe_n) && load_dac_strobe_n |->
      !write_strobe_n [*8] ##1 !write_strobe_n ##1 !write_strobe_n)
      else $error("write strobe pulse not ten cycles");
   a_data_setup: assert property ($fell(write_strobe_n) && load_dac_strobe_n |->
      $past(dac_data_lines, 2) == dac_data_lines && $past(byte_addr_lines, 2) == byte_addr_lines)
      else $error("data not set up before write strobe");
   a_data_stable: assert property (!write_strobe_n && $past(!write_strobe_n)
      && load_dac_strobe_n |-> $stable(dac_data_lines) && $stable(byte_addr_lines)
      && $stable(high_byte_select_n) && $stable(low_byte_select_n))
      else $error("pins moved during write strobe");
   a_load_selects: assert property (!load_dac_strobe_n && write_strobe_n |->
      high_byte_select_n && low_byte_select_n) else $error("selects low during load");
   a_byte_addr_used: assert property (!write_strobe_n && !byte_dev_select_n |->
      byte_addr_lines != LOC_IDLE) else $error("byte write to idle location");
   a_high_justified: assert property (!write_strobe_n && !byte_dev_select_n &&
      byte_addr_lines == LOC_HIGH |-> dac_data_lines[13:6] == 8'h00)
      else $error("high byte not right justified");
   a_low_on_bus: assert property (!write_strobe_n && !byte_dev_select_n &&
      byte_addr_lines == LOC_LOW |-> dac_data_lines[13:8] == 6'h00)
      else $error("low byte uses upper lines");
   a_low_follows: assert property (s_high_end |-> ##[1:40] s_low_write)
      else $error("low byte did not follow high byte");
   a_pready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready not after one wait state");
   a_err_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("pslverr outside an answer");
endmodule
`default_nettype wire

//--- dbl_pkg.sv
// Purpose: constants shared by the double-buffered dac host controller files
// Assumes: 100 MHz system clock; apb register words on 32-bit aligned offsets
// Notes: pin timing figures are plain defaults in ns, converted to cycles here
package dbl_pkg;

   // system clock period in ns
   localparam int CLK_PERIOD_NS = 10;

   // least data setup before the write strobe, strobe width, hold after it
   localparam int T_SETUP_NS = 20;
   localparam int T_STROBE_NS = 100;
   localparam int T_HOLD_NS = 20;

   // least times round up to whole cycles, at least one for any nonzero time
   localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] STROBE_CYC = 8'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_DATA = 8'h04;
   localparam logic [7:0] REG_CMD = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;

   // control fields
   localparam int CTRL_BYTE_MODE = 0;
   localparam int CTRL_TRANSPARENT = 1;
   localparam int CTRL_DEFER_LOAD = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   // command and status fields
   localparam int CMD_LOAD = 0;
   localparam int STAT_BUSY = 0;
   localparam int STAT_OVERRUN = 1;

   // code width and byte split
   localparam int CODE_W = 14;
   localparam int HIGH_W = 6;
   localparam logic [CODE_W-1:0] CODE_RESET = 14'h0000;

   // byte-wide variant write locations on the two low address lines
   localparam logic [1:0] LOC_IDLE = 2'h0;
   localparam logic [1:0] LOC_HIGH = 2'h1;
   localparam logic [1:0] LOC_LOW = 2'h2;
   localparam logic [1:0] LOC_LOAD = 2'h3;

   // sequence steps, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_WORD = 5'b00010,
      ST_HIGH = 5'b00100,
      ST_LOW = 5'b01000,
      ST_LOAD = 5'b10000
   } dbl_state_type;

   // pulse timer phases, one-hot
   typedef enum logic [3:0] {
      PH_IDLE = 4'b0001,
      PH_SETUP = 4'b0010,
      PH_STROBE = 4'b0100,
      PH_HOLD = 4'b1000
   } dbl_phase_type;

endpackage

//--- dbl_pulse_timer.sv
// Purpose: times one pin access: setup, strobe low window, hold
// Assumes: start is a one-cycle pulse given only while the timer is idle
// Notes: done pulses for one cycle at the end of the hold phase
`timescale 1ns/1ps
`default_nettype none
module dbl_pulse_timer
   import dbl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic start,
   output logic strobe,
   output logic done
);

   dbl_phase_type phase, next_phase; // current access phase
   logic [7:0] count, next_count; // cycles left in the phase
   logic next_strobe;
   logic next_done;

   // phase walk; a count reaching one ends its phase
   always_comb begin
      next_phase = phase;
      next_count = count;
      next_done = 1'b0;
      unique case (phase)
         PH_IDLE: begin
            if (start) begin
               next_phase = PH_SETUP;
               next_count = SETUP_CYC;
            end
         end
         PH_SETUP: begin
            if (count == 8'h01) begin
               next_phase = PH_STROBE;
               next_count = STROBE_CYC;
            end else begin
               next_count = count - 8'h01;
            end
         end
         PH_STROBE: begin
            if (count == 8'h01) begin
               next_phase = PH_HOLD;
               next_count = HOLD_CYC;
            end else begin
               next_count = count - 8'h01;
            end
         end
         PH_HOLD: begin
            if (count == 8'h01) begin
               next_phase = PH_IDLE;
               next_done = 1'b1;
            end else begin
               next_count = count - 8'h01;
            end
         end
      endcase
      next_strobe = (next_phase == PH_STROBE);
   end

   // registered so the strobe pin never glitches
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         phase <= PH_IDLE;
         count <= 8'h00;
         strobe <= 1'b0;
         done <= 1'b0;
      end else begin
         phase <= next_phase;
         count <= next_count;
         strobe <= next_strobe;
         done <= next_done;
      end
   end

endmodule
`default_nettype wire

//--- tb_dbl_host_ctrl.sv
// Purpose: self-checking bench for the dac host controller against two dac models
// Assumes: 100 MHz clock; apb master drives on the rising edge
// Notes: each scenario is its own task and judges its own results
`timescale 1ns/1ps
`default_nettype none
module tb_dbl_host_ctrl
   import dbl_pkg::*;
;
   logic clk_sys = 1'b0;
   logic nrst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [CODE_W-1:0] dac_data_lines, wordCode, byteCode;
   logic high_byte_select_n, low_byte_select_n, write_strobe_n, load_dac_strobe_n;
   logic byte_dev_select_n;
   logic [1:0] byte_addr_lines;
   int failures = 0;
   int checkCount = 0;
   always #5 clk_sys = ~clk_sys;
   dbl_host_ctrl dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dac_data_lines(dac_data_lines),
      .high_byte_select_n(high_byte_select_n), .low_byte_select_n(low_byte_select_n),
      .write_strobe_n(write_strobe_n), .load_dac_strobe_n(load_dac_strobe_n),
      .byte_dev_select_n(byte_dev_select_n), .byte_addr_lines(byte_addr_lines));
   dbl_dac_model dac (.dataLines(dac_data_lines), .highSelN(high_byte_select_n),
      .lowSelN(low_byte_select_n), .wrN(write_strobe_n), .loadN(load_dac_strobe_n),
      .byteSelN(byte_dev_select_n), .byteAddr(byte_addr_lines), .wordCode(wordCode),
      .byteCode(byteCode));
   // one apb transfer; pready, read data and error are taken at the rising edge
   // where pready is seen high, and only then is the request released
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
      output logic [31:0] rdata, output logic err);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) failures++;
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      logic [31:0] r;
      logic e;
      apb(1'b1, addr, data, r, e);
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checkCount++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // poll busy under a bounded count
   task automatic waitIdle;
      logic [31:0] r;
      logic e;
      int n;
      for (n = 0; n < 60; n++) begin
         apb(1'b0, REG_STATUS, 32'h0, r, e);
         if (r[STAT_BUSY] === 1'b0) break;
      end
      if (n == 60) failures++;
   endtask
   task automatic testReset;
      logic [31:0] r;
      logic e;
      apb(1'b0, REG_CTRL, 32'h0, r, e);
      chk("ctrl reset", 32'h0, r);
      apb(1'b0, 8'h10, 32'h0, r, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
   endtask
   // word-wide: one step into both input registers, then the load step
   task automatic testWord;
      logic [13:0] codes [3] = '{14'h3fff, 14'h2000, 14'h0001};
      wr(REG_CTRL, 32'h0);
      foreach (codes[i]) begin
         wr(REG_DATA, {18'h0, codes[i]});
         waitIdle();
         chk("word dac", {18'h0, codes[i]}, {18'h0, wordCode});
      end
   endtask
   task automatic testByte;
      logic [13:0] codes [2] = '{14'h3fc0, 14'h00a5};
      wr(REG_CTRL, 32'h1);
      foreach (codes[i]) begin
         wr(REG_DATA, {18'h0, codes[i]});
         waitIdle();
         chk("byte dac", {18'h0, codes[i]}, {18'h0, byteCode});
         chk("word hold", 32'h1, {18'h0, wordCode});
      end
      // deferred byte load: the code waits in the input registers
      wr(REG_CTRL, 32'h5);
      wr(REG_DATA, 32'h1555);
      waitIdle();
      chk("byte deferred", 32'h00a5, {18'h0, byteCode});
      wr(REG_CMD, 32'h1);
      waitIdle();
      chk("byte load", 32'h1555, {18'h0, byteCode});
   endtask
   task automatic testTransparent;
      wr(REG_CTRL, 32'h2);
      wr(REG_DATA, 32'h1234);
      repeat (3) @(posedge clk_sys);
      chk("transparent dac", 32'h1234, {18'h0, wordCode});
      wr(REG_CTRL, 32'h0);
   endtask
   // shared load: input registers filled first, dac moves only on the command
   task automatic testDefer;
      wr(REG_CTRL, 32'h4);
      wr(REG_DATA, 32'h0abc);
      waitIdle();
      chk("deferred hold", 32'h1234, {18'h0, wordCode});
      wr(REG_CMD, 32'h1);
      waitIdle();
      chk("shared load", 32'h0abc, {18'h0, wordCode});
   endtask
   task automatic testOverrun;
      logic [31:0] r;
      logic e;
      wr(REG_CTRL, 32'h0);
      wr(REG_DATA, 32'h1111);
      wr(REG_DATA, 32'h2222);
      apb(1'b0, REG_STATUS, 32'h0, r, e);
      chk("overrun", 32'h1, {31'h0, r[STAT_OVERRUN]});
      waitIdle();
      chk("first code kept", 32'h1111, {18'h0, wordCode});
      wr(REG_STATUS, 32'h2);
      apb(1'b0, REG_STATUS, 32'h0, r, e);
      chk("status cleared", 32'h0, r);
   endtask
   task automatic results;
      if (failures == 0 && checkCount > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      results();
   end
   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      testReset();
      testWord();
      testByte();
      testTransparent();
      testDefer();
      testOverrun();
      results();
   end
endmodule
bind dbl_host_ctrl dbl_host_ctrl_assertions chk_i (.clk_sys(clk_sys), .nrst(nrst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .dac_data_lines(dac_data_lines),
   .high_byte_select_n(high_byte_select_n), .low_byte_select_n(low_byte_select_n),
   .write_strobe_n(write_strobe_n), .load_dac_strobe_n(load_dac_strobe_n),
   .byte_dev_select_n(byte_dev_select_n), .byte_addr_lines(byte_addr_lines));
`default_nettype wire
